// >>> chain_pkg.sv
// Constants shared by the multidrop serial card addressing logic.
package chain_pkg;
  localparam logic [7:0] CH_CTRL_A = 8'h01;
  localparam logic [7:0] CH_CTRL_B = 8'h02;
  localparam logic [7:0] CH_CTRL_C = 8'h03;
  localparam logic [7:0] CH_CTRL_D = 8'h04;
  localparam logic [7:0] CH_CTRL_E = 8'h05;
  localparam logic [7:0] CH_CTRL_F = 8'h06;
  localparam logic [7:0] CH_CTRL_G = 8'h07;
  localparam logic [7:0] CH_BELL = 8'h07;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_CTRL_I = 8'h09;
  localparam logic [7:0] CH_CTRL_K = 8'h0b;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_CTRL_P = 8'h10;
  localparam logic [7:0] CH_CTRL_Q = 8'h11;
  localparam logic [7:0] CH_CTRL_R = 8'h12;
  localparam logic [7:0] CH_CTRL_S = 8'h13;
  localparam logic [7:0] CH_CTRL_T = 8'h14;
  localparam logic [7:0] CH_CTRL_V = 8'h16;
  localparam logic [7:0] CH_CTRL_W = 8'h17;
  localparam logic [7:0] CH_CTRL_X = 8'h18;
  localparam logic [7:0] CH_CTRL_Y = 8'h19;
  localparam logic [7:0] CH_CTRL_Z = 8'h1a;
  localparam logic [7:0] CH_SELECT = 8'h40;
  localparam logic [7:0] CH_CTRL_LIMIT = 8'h20;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [1:0] CHAIN_MODE_CTS = 2'h2;
  localparam logic [1:0] CHAIN_MODE_NOCTS = 2'h3;
  localparam int LINE_DEPTH = 32;
  localparam int LINE_AW = 5;
  localparam logic [3:0] CARD_ZERO = 4'h0;
  localparam logic [LINE_AW:0] LINE_LEN_RESET = 6'h00;
endpackage : chain_pkg

// >>> char_classify.sv
// Combinational classifier of one received character.
`timescale 1ns/100ps
module char_classify
  import chain_pkg::*;
(
  // Character in.
  input wire logic [7:0] ch,
  // Classes out.
  output logic is_ctrl,
  output logic is_bcast,
  output logic is_reply,
  output logic is_hex,
  output logic [3:0] hex_val
);
  // [R20] ASCII control decode
  always_comb
  begin
    is_ctrl = (ch < CH_CTRL_LIMIT);
    is_bcast = 1'b0;
    is_reply = 1'b0;
    unique case (ch)
      CH_CTRL_A, CH_CTRL_D, CH_CTRL_I, CH_CTRL_K, CH_CR, CH_CTRL_Q,
      CH_CTRL_R, CH_CTRL_S, CH_CTRL_W, CH_CTRL_X, CH_CTRL_Z: is_bcast = 1'b1;
      CH_CTRL_B, CH_CTRL_C, CH_CTRL_E, CH_CTRL_F, CH_CTRL_G, CH_CTRL_P,
      CH_CTRL_V, CH_CTRL_Y: is_reply = 1'b1;
      default: ;
    endcase
    is_hex = 1'b1;
    hex_val = 4'h0;
    if (ch >= 8'h30 && ch <= 8'h39)
      hex_val = 4'(ch - 8'h30);
    else if (ch >= 8'h41 && ch <= 8'h46)
      hex_val = 4'(ch - 8'h37);
    else if (ch >= 8'h61 && ch <= 8'h66)
      hex_val = 4'(ch - 8'h57);
    else
      is_hex = 1'b0;
  end
endmodule : char_classify

// >>> card_addressing.sv
// Per-card command interpreter for a shared multidrop serial line.
`timescale 1ns/100ps
// What this block does
// [R1] Broadcast select: all cards collect alphanumerics.
// [R2] Broadcast: only card zero drives replies.
// [R3] Broadcast query: card zero rings bell.
// [R4] Buffered line waits for carriage return.
// [R5] Host queries one card per line.
// [R6] Reset in chain modes 2 and 3: card zero addressed, others not.
// [R7] No-reply control characters reach every card.
// [R8] Carriage return executes each collected line.
// [R9] Empty line at return is no-op.
// [R10] Reply control characters: addressed card only.
// [R11] Broadcast mode rejects reply control characters.
// [R12] Reply controls use last completed address.
// [R13] Host sends return before reply controls.
// [R14] Backspace erases back to last return.
// [R15] Backspace also cancels pending select.
// [R16] Never echo; reject duplex toggle.
// [R17] Select prefix plus hex digit addresses card.
// [R18] Unaddressed: ignore alphanumerics except the one completing a select, release outputs.
// [R19] Chain mode three ignores clear-to-send.
// [R20] Control characters by ASCII, never stored.
// [R21] Pending address becomes active at return.
module card_addressing
  import chain_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Configuration straps and chain mode.
  input wire logic [3:0] card_num,
  input wire logic [1:0] chain_mode_variable,
  // Received character stream.
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Handshake from the host, asynchronous pin.
  input wire logic cts_pin,
  // Reply character stream from the card's core.
  input wire logic reply_valid,
  input wire logic [7:0] reply_char,
  // Serial reply and handshake pins.
  output logic tx_valid,
  output logic [7:0] tx_char,
  output logic tx_oe,
  output logic hs_oe,
  output logic tx_hold,
  // Execution strobes toward the core.
  output logic exec_line,
  output logic exec_nop,
  output logic [7:0] exec_len,
  output logic ctrl_exec,
  output logic [7:0] ctrl_char,
  // Addressing state.
  output logic addressed,
  output logic bcast_mode,
  // Line buffer read port.
  input wire logic [LINE_AW-1:0] line_rd_idx,
  output logic [7:0] line_rd_data
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PREFIX = 3'b010,
    ST_DIGIT = 3'b100
  } sel_e;
  sel_e sel_r;
  logic is_ctrl, is_bcast, is_reply, is_hex;
  logic [3:0] hex_val;
  logic [7:0] line_r [LINE_DEPTH];
  logic [LINE_AW:0] len_r;
  logic [LINE_AW:0] sel_pos_r;
  logic addressed_r, bcast_r, boot_r;
  logic pend_valid_r, pend_bcast_r;
  logic [3:0] pend_num_r;
  logic cts_s1_r, cts_s2_r;
  logic alnum, cr_evt, bs_evt;
  logic pend_sel_nxt, pend_bc_nxt;
  char_classify u_cls (
    .ch(rx_char),
    .is_ctrl(is_ctrl),
    .is_bcast(is_bcast),
    .is_reply(is_reply),
    .is_hex(is_hex),
    .hex_val(hex_val)
  );
  assign alnum = rx_valid && !is_ctrl;
  assign cr_evt = rx_valid && rx_char == CH_CR;
  assign bs_evt = rx_valid && rx_char == CH_BS;
  // [R17] Select decode
  always_comb
  begin
    pend_sel_nxt = 1'b0;
    pend_bc_nxt = 1'b0;
    if (alnum && sel_r == ST_PREFIX)
    begin
      pend_sel_nxt = (rx_char == CH_SELECT) || is_hex;
      pend_bc_nxt = (rx_char == CH_SELECT);
    end
  end

  // Select parser tracks prefix; the stream is watched even when unaddressed.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sel_r <= ST_IDLE;
    else if (cr_evt || bs_evt)
      sel_r <= ST_IDLE;
    else if (alnum)
    begin
      if (sel_r == ST_PREFIX)
        sel_r <= pend_sel_nxt ? ST_DIGIT : ST_IDLE;
      else
        sel_r <= (rx_char == CH_SELECT) ? ST_PREFIX : ST_IDLE;
    end
  end

  // [R21] Pending select capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_valid_r <= 1'b0;
      pend_bcast_r <= 1'b0;
      pend_num_r <= CARD_ZERO;
      sel_pos_r <= LINE_LEN_RESET;
    end
    else if (cr_evt)
      pend_valid_r <= 1'b0;
    // [R15] Erase cancels select
    else if (bs_evt && pend_valid_r && len_r <= sel_pos_r)
      pend_valid_r <= 1'b0;
    else if (pend_sel_nxt)
    begin
      pend_valid_r <= 1'b1;
      pend_bcast_r <= pend_bc_nxt;
      pend_num_r <= hex_val;
      sel_pos_r <= len_r + 1'b1;
    end
  end

  // [R6] Reset address state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addressed_r <= 1'b0;
      bcast_r <= 1'b0;
    end
    else if (!(chain_mode_variable == CHAIN_MODE_CTS || chain_mode_variable == CHAIN_MODE_NOCTS))
    begin
      addressed_r <= 1'b1;
      bcast_r <= 1'b0;
    end
    else if (boot_r)
      addressed_r <= (card_num == CARD_ZERO);
    // [R21] Activate at return
    else if (cr_evt && pend_valid_r)
    begin
      addressed_r <= pend_bcast_r || (pend_num_r == card_num);
      bcast_r <= pend_bcast_r;
    end
  end

  // [R6] Strap caught after release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      boot_r <= 1'b1;
    else
      boot_r <= 1'b0;
  end
  wire boot_addr = boot_r && card_num == CARD_ZERO;
  wire is_addr = boot_r ? boot_addr : addressed_r;
  // [R3] Broadcast query never stored
  wire store_ok = alnum && (is_addr || pend_sel_nxt) && !(bcast_r && rx_char == CH_QUERY)
                  && len_r < (LINE_AW+1)'(LINE_DEPTH);

  // [R18] Alphanumerics only when addressed or when the character completes a select
  // [R1] Broadcast cards collect too
  // [R14] Backspace trims to last return
  // [R20] Control characters not stored
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      len_r <= LINE_LEN_RESET;
    else if (cr_evt)
      len_r <= LINE_LEN_RESET;
    else if (bs_evt && len_r != LINE_LEN_RESET)
      len_r <= len_r - 1'b1;
    else if (store_ok)
      len_r <= len_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (store_ok)
      line_r[len_r[LINE_AW-1:0]] <= rx_char;
  end
  assign line_rd_data = line_r[line_rd_idx];

  // [R4] Execute only on return
  // [R8] Every card executes line
  // [R9] Empty line is no-op
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      exec_line <= 1'b0;
      exec_nop <= 1'b0;
      exec_len <= 8'h00;
    end
    else
    begin
      exec_line <= cr_evt && len_r != LINE_LEN_RESET;
      exec_nop <= cr_evt && len_r == LINE_LEN_RESET;
      if (cr_evt)
        exec_len <= 8'(len_r);
    end
  end

  // [R7] Broadcast controls everywhere
  // [R10] Reply controls addressed only
  // [R11] Broadcast rejects reply controls
  // [R12] Uses completed address
  // [R16] Duplex toggle rejected
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_exec <= 1'b0;
      ctrl_char <= 8'h00;
    end
    else
    begin
      ctrl_exec <= rx_valid && ((is_bcast && rx_char != CH_CR)
                   || (is_reply && is_addr && !bcast_r));
      if (rx_valid && is_ctrl)
        ctrl_char <= rx_char;
    end
  end

  // Two flops on the asynchronous clear-to-send pin.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cts_s1_r <= 1'b1;
      cts_s2_r <= 1'b1;
    end
    else
    begin
      cts_s1_r <= cts_pin;
      cts_s2_r <= cts_s1_r;
    end
  end

  // [R2] Only card zero answers broadcast
  // [R3] Bell for broadcast query
  // [R16] No echo of received characters
  // [R18] Release outputs when unaddressed
  // [R19] Mode three ignores clear-to-send
  wire drive_ok = is_addr && (!bcast_r || card_num == CARD_ZERO);
  wire bell_evt = bcast_r && card_num == CARD_ZERO && alnum && rx_char == CH_QUERY;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_valid <= 1'b0;
      tx_char <= 8'h00;
      tx_oe <= 1'b0;
      hs_oe <= 1'b0;
      tx_hold <= 1'b0;
    end
    else
    begin
      tx_oe <= drive_ok;
      hs_oe <= drive_ok;
      tx_hold <= drive_ok && chain_mode_variable != CHAIN_MODE_NOCTS && !cts_s2_r;
      tx_valid <= bell_evt || (drive_ok && !bcast_r && reply_valid);
      tx_char <= bell_evt ? CH_BELL : reply_char;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addressed <= 1'b0;
      bcast_mode <= 1'b0;
    end
    else
    begin
      addressed <= is_addr;
      bcast_mode <= bcast_r;
    end
  end

  property p_bcast_no_reply;
    @(posedge clk) disable iff (!rstn) (rx_valid && is_reply && bcast_r) |=> !ctrl_exec;
  endproperty
  a_bcast_no_reply: assert property (p_bcast_no_reply) else $error("reply control ran in broadcast"); // [R11]
  property p_bcast_ctrl;
    @(posedge clk) disable iff (!rstn) (rx_valid && is_bcast && rx_char != CH_CR) |=> ctrl_exec;
  endproperty
  a_bcast_ctrl: assert property (p_bcast_ctrl) else $error("broadcast control dropped"); // [R7]
  property p_cr_exec;
    @(posedge clk) disable iff (!rstn) cr_evt |=> (exec_line ^ exec_nop);
  endproperty
  a_cr_exec: assert property (p_cr_exec) else $error("return not executed"); // [R8]
  property p_nop;
    @(posedge clk) disable iff (!rstn) (cr_evt && len_r == LINE_LEN_RESET) |=> exec_nop;
  endproperty
  a_nop: assert property (p_nop) else $error("empty line not no-op"); // [R9]
  property p_no_early_exec;
    @(posedge clk) disable iff (!rstn) !$past(cr_evt) |-> !exec_line;
  endproperty
  a_no_early_exec: assert property (p_no_early_exec) else $error("line ran before return"); // [R4]
  property p_only_zero;
    @(posedge clk) disable iff (!rstn) (bcast_r && card_num != CARD_ZERO) |=> !tx_oe;
  endproperty
  a_only_zero: assert property (p_only_zero) else $error("nonzero card drove in broadcast"); // [R2]
  property p_bell;
    @(posedge clk) disable iff (!rstn) bell_evt |=> (tx_valid && tx_char == CH_BELL);
  endproperty
  a_bell: assert property (p_bell) else $error("no bell for broadcast query"); // [R3]
  property p_bs;
    @(posedge clk) disable iff (!rstn) (bs_evt && len_r != LINE_LEN_RESET) |=> len_r == $past(len_r) - 1'b1;
  endproperty
  a_bs: assert property (p_bs) else $error("backspace did not erase"); // [R14]
  property p_unaddr;
    @(posedge clk) disable iff (!rstn) (!is_addr && !pend_sel_nxt && alnum && !cr_evt) |=> $stable(len_r);
  endproperty
  a_unaddr: assert property (p_unaddr) else $error("unaddressed card stored"); // [R18]
  c_bcast: cover property (@(posedge clk) disable iff (!rstn) $rose(bcast_r));
  c_bell: cover property (@(posedge clk) disable iff (!rstn) bell_evt);
  c_exec: cover property (@(posedge clk) disable iff (!rstn) exec_line);
  c_readdr: cover property (@(posedge clk) disable iff (!rstn) $fell(addressed_r));
endmodule : card_addressing

// >>> host_line.sv
// Host model on the shared serial line: sends characters and drives clear-to-send.
`timescale 1ns/100ps
module host_line
(
  // Clock.
  input wire logic clk,
  // Character stream and handshake toward the cards.
  output logic rx_valid,
  output logic [7:0] rx_char,
  output logic cts_pin
);
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    cts_pin = 1'b1;
  end
  // Ordered host stream.
  // Callers keep one query per line and a return after each select.
  // Idle data shows the inverse of the last byte so stale data never passes for a fresh one.
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask : send
  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_pin <= v;
  endtask : set_cts
endmodule : host_line

// >>> test_multidrop_serial_card_addressing.sv
// Self-checking bench for the per-card serial addressing logic.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_multidrop_serial_card_addressing
  import chain_pkg::*;
;
  logic clk = 1'b0, rstn, rx_valid, cts_pin, reply_valid;
  logic [3:0] card_num;
  logic [1:0] chain_mode_variable;
  logic [7:0] rx_char, reply_char, tx_char, exec_len, ctrl_char, line_rd_data;
  logic [4:0] line_rd_idx;
  logic tx_valid, tx_oe, hs_oe, tx_hold, exec_line, exec_nop, ctrl_exec, addressed, bcast_mode;
  int n_fail = 0, tests_run = 0, n_line, n_nop, n_ctrl, n_tx;
  logic [7:0] last_len, last_ctrl, last_tx;
  logic [7:0] nr[10] = '{CH_CTRL_A, CH_CTRL_D, CH_CTRL_I, CH_CTRL_K, CH_CTRL_Q, CH_CTRL_R,
                         CH_CTRL_S, CH_CTRL_W, CH_CTRL_X, CH_CTRL_Z};
  logic [7:0] rp[8] = '{CH_CTRL_B, CH_CTRL_C, CH_CTRL_E, CH_CTRL_F, CH_CTRL_G, CH_CTRL_P,
                        CH_CTRL_V, CH_CTRL_Y};

  always #5 clk = ~clk;

  host_line i_host (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char), .cts_pin(cts_pin));

  card_addressing i_dut (.clk(clk), .rstn(rstn), .card_num(card_num),
    .chain_mode_variable(chain_mode_variable), .rx_valid(rx_valid), .rx_char(rx_char),
    .cts_pin(cts_pin), .reply_valid(reply_valid), .reply_char(reply_char),
    .tx_valid(tx_valid), .tx_char(tx_char), .tx_oe(tx_oe), .hs_oe(hs_oe), .tx_hold(tx_hold),
    .exec_line(exec_line), .exec_nop(exec_nop), .exec_len(exec_len), .ctrl_exec(ctrl_exec),
    .ctrl_char(ctrl_char), .addressed(addressed), .bcast_mode(bcast_mode),
    .line_rd_idx(line_rd_idx), .line_rd_data(line_rd_data));

  // Pulses last one cycle, so they are counted here rather than polled by the scenarios.
  always @(posedge clk)
  begin
    if (exec_line === 1'b1)
    begin
      n_line++;
      last_len = exec_len;
    end
    if (exec_nop === 1'b1)
      n_nop++;
    if (ctrl_exec === 1'b1)
    begin
      n_ctrl++;
      last_ctrl = ctrl_char;
    end
    if (tx_valid === 1'b1)
    begin
      n_tx++;
      last_tx = tx_char;
    end
  end

  task automatic clr();
    n_line = 0;
    n_nop = 0;
    n_ctrl = 0;
    n_tx = 0;
  endtask : clr

  task automatic gap();
    repeat (3) @(posedge clk);
  endtask : gap

  task automatic do_reset(input logic [3:0] num, input logic [1:0] mode);
    @(posedge clk);
    card_num <= num;
    chain_mode_variable <= mode;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    gap();
    clr();
  endtask : do_reset

  task automatic t_power_up();
    do_reset(4'h0, 2'h2);
    `CHK(addressed, 1'b1)
    do_reset(4'h3, 2'h3);
    `CHK(addressed, 1'b0)
    `CHK(tx_oe, 1'b0)
    `CHK(hs_oe, 1'b0)
  endtask : t_power_up

  task automatic t_select();
    foreach (rp[i]) i_host.send(rp[i]);
    foreach (nr[i])
    begin
      i_host.send(nr[i]);
      gap();
      `CHK(last_ctrl, nr[i])
    end
    `CHK(n_ctrl, 10)
    i_host.send(CH_SELECT);
    i_host.send(8'h33);
    gap();
    `CHK(addressed, 1'b0)
    i_host.send(CH_CR);
    gap();
    // An unaddressed card keeps only the digit that completes its select.
    `CHK(n_line, 1)
    `CHK(last_len, 8'h01)
    `CHK(addressed, 1'b1)
    `CHK(line_rd_data, 8'h33)
  endtask : t_select

  task automatic t_edit();
    clr();
    i_host.send(8'h41);
    i_host.send(8'h42);
    gap();
    `CHK(n_line, 0)
    line_rd_idx <= 5'h01;
    @(posedge clk);
    `CHK(line_rd_data, 8'h42)
    line_rd_idx <= 5'h00;
    i_host.send(CH_BS);
    i_host.send(CH_CR);
    gap();
    `CHK(last_len, 8'h01)
    i_host.send(CH_BS);
    i_host.send(CH_CR);
    gap();
    `CHK(n_nop, 1)
    i_host.send(CH_SELECT);
    i_host.send(8'h35);
    i_host.send(CH_BS);
    i_host.send(CH_BS);
    i_host.send(CH_CR);
    gap();
    `CHK(n_nop, 2)
    `CHK(addressed, 1'b1)
    i_host.send(CH_SELECT);
    i_host.send(8'h35);
    i_host.send(CH_BS);
    i_host.send(CH_CR);
    gap();
    `CHK(last_len, 8'h01)
    `CHK(addressed, 1'b1)
  endtask : t_edit

  task automatic t_ctrl();
    clr();
    i_host.send(CH_SELECT);
    i_host.send(8'h35);
    i_host.send(CH_CTRL_B);
    gap();
    `CHK(n_ctrl, 1)
    i_host.send(CH_CR);
    gap();
    `CHK(addressed, 1'b0)
    i_host.send(CH_CTRL_T);
    gap();
    `CHK(n_ctrl, 1)
    `CHK(n_tx, 0)
    do_reset(4'h0, 2'h2);
    foreach (rp[i])
    begin
      i_host.send(rp[i]);
      gap();
      `CHK(last_ctrl, rp[i])
    end
    `CHK(n_line, 0)
  endtask : t_ctrl

  task automatic t_bcast(input logic [3:0] num);
    do_reset(num, 2'h2);
    i_host.send(CH_SELECT);
    i_host.send(CH_SELECT);
    i_host.send(CH_CR);
    gap();
    `CHK(bcast_mode, 1'b1)
    `CHK(hs_oe, num == 4'h0)
    i_host.send(CH_QUERY);
    i_host.send(CH_CTRL_P);
    gap();
    `CHK(n_tx, int'(num == 4'h0))
    if (num == 4'h0)
      `CHK(last_tx, CH_BELL)
    `CHK(n_ctrl, 0)
    i_host.send(8'h5a);
    i_host.send(CH_CR);
    gap();
    `CHK(last_len, 8'h01)
  endtask : t_bcast

  task automatic t_reply_cts();
    do_reset(4'h0, 2'h2);
    reply_valid <= 1'b1;
    reply_char <= 8'h41;
    @(posedge clk);
    reply_valid <= 1'b0;
    gap();
    `CHK(last_tx, 8'h41)
    i_host.set_cts(1'b0);
    // Two synchroniser stages and the output flop.
    gap();
    @(posedge clk);
    `CHK(tx_hold, 1'b1)
    do_reset(4'h0, 2'h3);
    `CHK(tx_hold, 1'b0)
    i_host.set_cts(1'b1);
  endtask : t_reply_cts

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // A hung run is cut short and counted as a mismatch.
  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end

  initial
  begin
    rstn <= 1'b0;
    card_num <= 4'h0;
    chain_mode_variable <= 2'h2;
    reply_valid <= 1'b0;
    reply_char <= 8'h00;
    line_rd_idx <= 5'h00;
    t_power_up();
    t_select();
    t_edit();
    t_ctrl();
    t_bcast(4'h0);
    t_bcast(4'h3);
    t_reply_cts();
    test_done();
  end
endmodule : test_multidrop_serial_card_addressing
